// >>> pump_fan_staging_pkg.sv
package pump_fan_staging_pkg;

   // ---------------------------------------------
   // Clock and timing
   // ---------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int CTRL_TICK_US = 1000;
   localparam int CTRL_TICK_CYC = (CTRL_TICK_US * 1000) / CLK_PERIOD_NS;

   // ---------------------------------------------
   // Frequency scale: 0.1 Hz per count
   // ---------------------------------------------
   localparam logic [15:0] FREQ_ONE_HZ = 16'h000a;
   localparam int NUM_RELAYS = 6;
   localparam int NUM_LEVELS = 3;

   // ---------------------------------------------
   // Register byte offsets
   // ---------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_REFERENCE = 8'h04;
   localparam logic [7:0] REG_START_LIM0 = 8'h08;
   localparam logic [7:0] REG_LOW_LIM0 = 8'h14;
   localparam logic [7:0] REG_START_DLY = 8'h20;
   localparam logic [7:0] REG_STOP_DLY = 8'h24;
   localparam logic [7:0] REG_AUX_MAX = 8'h28;
   localparam logic [7:0] REG_RELAY_MASK = 8'h2c;
   localparam logic [7:0] REG_ROT_INTERVAL = 8'h30;
   localparam logic [7:0] REG_GAIN = 8'h34;
   localparam logic [7:0] REG_FREQ_MIN = 8'h38;
   localparam logic [7:0] REG_FREQ_MAX = 8'h3c;
   localparam logic [7:0] REG_STATUS = 8'h40;
   localparam logic [7:0] REG_RELAY_STAT = 8'h44;

   // Register word indices
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_REFERENCE = 4'h1;
   localparam logic [3:0] IDX_START_LIM0 = 4'h2;
   localparam logic [3:0] IDX_LOW_LIM0 = 4'h5;
   localparam logic [3:0] IDX_START_DLY = 4'h8;
   localparam logic [3:0] IDX_STOP_DLY = 4'h9;
   localparam logic [3:0] IDX_AUX_MAX = 4'ha;
   localparam logic [3:0] IDX_RELAY_MASK = 4'hb;
   localparam logic [3:0] IDX_ROT_INTERVAL = 4'hc;
   localparam logic [3:0] IDX_GAIN = 4'hd;
   localparam logic [3:0] IDX_FREQ_MIN = 4'he;
   localparam logic [3:0] IDX_FREQ_MAX = 4'hf;

   // Control register fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_INTERLOCK_BIT = 1;
   localparam int CTRL_ROTATE_BIT = 2;

   // Status register fields
   localparam int STAT_AUX_LSB = 16;
   localparam int STAT_STATE_LSB = 20;
   localparam int RSTAT_ROT_LSB = 8;
   localparam int RSTAT_ILK_LSB = 16;

   // Reset values (frequencies in 0.1 Hz, delays in control ticks)
   localparam logic [31:0] CFG_RESET [16] = '{
      32'h0000_0000, 32'h0000_0000,
      32'h0000_01f4, 32'h0000_01f4, 32'h0000_01f4,
      32'h0000_0190, 32'h0000_0190, 32'h0000_0190,
      32'h0000_0bb8, 32'h0000_0bb8,
      32'h0000_0003, 32'h0000_000f, 32'h0000_0000,
      32'h0000_1008, 32'h0000_0000, 32'h0000_01f4};

   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_START_WAIT = 3'b010,
      ST_STOP_WAIT = 3'b100
   } stage_state_t;

   typedef struct packed {
      logic [15:0] kp;
      logic [15:0] ki;
      logic [15:0] fmin;
      logic [15:0] fmax;
   } loop_cfg_t;

   typedef struct packed {
      logic valid;
      logic up;
      logic [15:0] amount;
   } freq_step_t;

endpackage

// >>> freq_loop.sv
`timescale 1ns/1ps
`default_nettype none

module freq_loop (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_i,
   input wire logic tick_i,
   input wire logic [15:0] reference_i,
   input wire logic [15:0] feedback_i,
   input wire pump_fan_staging_pkg::loop_cfg_t cfg_i,
   input wire pump_fan_staging_pkg::freq_step_t step_i,
   output logic [15:0] freq_o
);

   logic [15:0] freq_q;
   logic [15:0] freq_d;
   logic signed [16:0] err_q;
   logic signed [16:0] err_d;

   function automatic logic [15:0] clamp(input logic signed [31:0] v,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
      logic [15:0] r;
      r = v[15:0];
      if (v < $signed({16'h0000, lo})) begin
         r = lo;
      end else if (v > $signed({16'h0000, hi})) begin
         r = hi;
      end
      return r;
   endfunction

   // ---------------------------------------------
   // Incremental PI loop with step override
   // ---------------------------------------------
   always_comb begin
      logic signed [31:0] delta;
      logic signed [31:0] sum;
      delta = 32'sh0;
      sum = 32'sh0;
      err_d = err_q;
      freq_d = freq_q;
      if (!enable_i) begin
         err_d = 17'sh0;
         freq_d = cfg_i.fmin;
      end else if (step_i.valid) begin
         // Staging step takes the cycle, the loop resumes on the next tick
         if (step_i.up) begin
            sum = $signed({16'h0000, freq_q}) + $signed({16'h0000, step_i.amount});
         end else begin
            sum = $signed({16'h0000, freq_q}) - $signed({16'h0000, step_i.amount});
         end
         freq_d = clamp(sum, cfg_i.fmin, cfg_i.fmax);
      end else if (tick_i) begin
         // Frequency trims so the feedback follows the reference
         err_d = $signed({1'b0, reference_i}) - $signed({1'b0, feedback_i});
         delta = ($signed({16'h0000, cfg_i.kp}) * 32'(err_d - err_q)
                  + $signed({16'h0000, cfg_i.ki}) * 32'(err_d)) >>> 8;
         sum = $signed({16'h0000, freq_q}) + delta;
         freq_d = clamp(sum, cfg_i.fmin, cfg_i.fmax);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         freq_q <= 16'h0000;
         err_q <= 17'sh0;
      end else begin
         freq_q <= freq_d;
         err_q <= err_d;
      end
   end

   assign freq_o = freq_q;

endmodule

`default_nettype wire

// >>> pump_fan_staging.sv
// Notes on behaviour
// - The first motor is the speed-regulated one; its frequency sets capacity.
// - Auxiliary line motors switch on and off one after another in order.
// - A PI loop trims the regulated frequency so feedback follows reference.
// - Frequency above the start limit starts one auxiliary motor automatically.
// - After a start the regulated frequency drops, then the loop resumes.
// - Rising demand adds further auxiliaries one at a time, same procedure.
// - Frequency below the low limit stops one auxiliary motor automatically.
// - After a stop the regulated frequency rises to make up lost output.
// - With interlock on, out-of-service motors are skipped for the next one.
// - Duty rotation moves the regulated role to the next motor periodically.
// - Start needs limit plus 1 Hz, then above limit minus 1 Hz all delay.
// - Stop needs low minus 1 Hz, then below low plus 1 Hz all delay.
// - Start steps frequency down by start minus low; stop steps it up.
// - Auxiliaries take staging relays in ascending order, rotated when rotating.
`timescale 1ns/1ps
`default_nettype none

module pump_fan_staging #(
   parameter int CTRL_TICK_CYC = pump_fan_staging_pkg::CTRL_TICK_CYC
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] feedback_i,
   input wire logic [5:0] out_of_service_i,
   output logic [5:0] relay_o,
   output logic [15:0] freq_o
);

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [2:0] wrap6(input logic [3:0] v);
      logic [3:0] r;
      r = (v >= 4'h6) ? v - 4'h6 : v;
      return r[2:0];
   endfunction

   // Scan staging relays after base; last==0 gives first free, last==1 gives last running
   function automatic logic [3:0] scan(input logic [5:0] mask, input logic [5:0] run,
                                       input logic [5:0] blocked, input logic [2:0] base,
                                       input logic last);
      logic [3:0] res;
      logic [2:0] idx;
      res = 4'h0;
      for (int p = 1; p <= 6; p++) begin
         idx = wrap6({1'b0, base} + 4'(p));
         if (!last && res[3] == 1'b0 && mask[idx] && !run[idx] && !blocked[idx]) begin
            res = {1'b1, idx};
         end
         if (last && mask[idx] && run[idx]) begin
            res = {1'b1, idx};
         end
      end
      return res;
   endfunction

   function automatic logic [1:0] level(input logic [2:0] n);
      return (n >= 3'd2) ? 2'd2 : n[1:0];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = dat[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ---------------------------------------------
   // Register file and Wishbone slave
   // ---------------------------------------------
   logic [31:0] cfg_q [16];
   logic [31:0] cfg_d [16];
   logic ack_q;
   logic ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic req;

   pump_fan_staging_pkg::stage_state_t state_q;
   pump_fan_staging_pkg::stage_state_t state_d;
   logic [5:0] run_q;
   logic [5:0] run_d;
   logic [2:0] aux_cnt_q;
   logic [2:0] aux_cnt_d;
   logic [2:0] rot_q;
   logic [2:0] rot_d;
   logic [31:0] dly_cnt_q;
   logic [31:0] dly_cnt_d;
   logic [31:0] rot_cnt_q;
   logic [31:0] rot_cnt_d;
   logic [31:0] tick_cnt_q;
   logic [31:0] tick_cnt_d;
   logic [5:0] relay_q;
   logic [5:0] relay_d;
   pump_fan_staging_pkg::freq_step_t step_q;
   pump_fan_staging_pkg::freq_step_t step_d;
   logic [15:0] freq;

   assign req = wb_cyc_i && wb_stb_i && !ack_q;

   always_comb begin
      for (int i = 0; i < 16; i++) begin
         cfg_d[i] = cfg_q[i];
      end
      ack_d = req;
      rdat_d = 32'h0000_0000;
      // Write lands at the edge where the master sees ack
      if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_adr_i[7:6] == 2'b00 && wb_adr_i[1:0] == 2'b00) begin
         cfg_d[wb_adr_i[5:2]] = merge(cfg_q[wb_adr_i[5:2]], wb_dat_i, wb_sel_i);
      end
      if (req && !wb_we_i) begin
         if (wb_adr_i[7:6] == 2'b00) begin
            rdat_d = cfg_q[wb_adr_i[5:2]];
         end else if (wb_adr_i == pump_fan_staging_pkg::REG_STATUS) begin
            rdat_d = {9'h000, state_q, 1'b0, aux_cnt_q, freq};
         end else if (wb_adr_i == pump_fan_staging_pkg::REG_RELAY_STAT) begin
            rdat_d = {10'h000, out_of_service_i, 5'h00, rot_q, 2'b00, relay_q};
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 16; i++) begin
            cfg_q[i] <= pump_fan_staging_pkg::CFG_RESET[i];
         end
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < 16; i++) begin
            cfg_q[i] <= cfg_d[i];
         end
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ---------------------------------------------
   // Configuration decode
   // ---------------------------------------------
   logic enable;
   logic ilk_en;
   logic rot_en;
   logic [5:0] mask;
   logic [5:0] blocked;
   logic [2:0] base;
   logic [3:0] next_free;
   logic [3:0] last_run;
   logic [3:0] next_reg;
   logic [1:0] lvl_up;
   logic [1:0] lvl_dn;
   logic [16:0] s_up;
   logic [16:0] l_up;
   logic [16:0] s_dn;
   logic [16:0] l_dn;
   logic [16:0] f17;
   logic [16:0] hz;
   logic tick;
   logic can_start;
   pump_fan_staging_pkg::loop_cfg_t loop_cfg;

   assign enable = cfg_q[pump_fan_staging_pkg::IDX_CTRL][pump_fan_staging_pkg::CTRL_ENABLE_BIT];
   assign ilk_en = cfg_q[pump_fan_staging_pkg::IDX_CTRL][pump_fan_staging_pkg::CTRL_INTERLOCK_BIT];
   assign rot_en = cfg_q[pump_fan_staging_pkg::IDX_CTRL][pump_fan_staging_pkg::CTRL_ROTATE_BIT];
   assign mask = cfg_q[pump_fan_staging_pkg::IDX_RELAY_MASK][5:0];
   assign blocked = ilk_en ? out_of_service_i : 6'h00;
   // Without rotation the scan starts at relay 0; with it, after the regulated relay
   assign base = rot_en ? rot_q : 3'd5;
   assign next_free = scan(mask, run_q | (rot_en ? 6'(1) << rot_q : 6'h00), blocked, base, 1'b0);
   assign last_run = scan(mask, run_q, 6'h00, base, 1'b1);
   assign next_reg = scan(mask, 6'h00, blocked, rot_q, 1'b0);
   assign lvl_up = level(aux_cnt_q);
   assign lvl_dn = level(aux_cnt_q - 3'd1);
   assign s_up = {1'b0, cfg_q[pump_fan_staging_pkg::IDX_START_LIM0 + 4'(lvl_up)][15:0]};
   assign l_up = {1'b0, cfg_q[pump_fan_staging_pkg::IDX_LOW_LIM0 + 4'(lvl_up)][15:0]};
   assign s_dn = {1'b0, cfg_q[pump_fan_staging_pkg::IDX_START_LIM0 + 4'(lvl_dn)][15:0]};
   assign l_dn = {1'b0, cfg_q[pump_fan_staging_pkg::IDX_LOW_LIM0 + 4'(lvl_dn)][15:0]};
   assign f17 = {1'b0, freq};
   assign hz = {1'b0, pump_fan_staging_pkg::FREQ_ONE_HZ};
   assign tick = tick_cnt_q >= 32'(CTRL_TICK_CYC - 1);
   assign can_start = next_free[3] && aux_cnt_q < cfg_q[pump_fan_staging_pkg::IDX_AUX_MAX][2:0];
   assign loop_cfg = '{kp: {8'h00, cfg_q[pump_fan_staging_pkg::IDX_GAIN][7:0]},
                       ki: {8'h00, cfg_q[pump_fan_staging_pkg::IDX_GAIN][15:8]},
                       fmin: cfg_q[pump_fan_staging_pkg::IDX_FREQ_MIN][15:0],
                       fmax: cfg_q[pump_fan_staging_pkg::IDX_FREQ_MAX][15:0]};

   // ---------------------------------------------
   // Staging sequencer
   // ---------------------------------------------
   always_comb begin
      state_d = state_q;
      run_d = run_q;
      aux_cnt_d = aux_cnt_q;
      rot_d = rot_q;
      dly_cnt_d = dly_cnt_q;
      rot_cnt_d = rot_cnt_q;
      tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      step_d = '{valid: 1'b0, up: 1'b0, amount: 16'h0000};
      if (!enable) begin
         state_d = pump_fan_staging_pkg::ST_IDLE;
         run_d = 6'h00;
         aux_cnt_d = 3'd0;
         dly_cnt_d = 32'h0000_0000;
         rot_cnt_d = 32'h0000_0000;
      end else begin
         case (state_q)
            pump_fan_staging_pkg::ST_IDLE: begin
               dly_cnt_d = 32'h0000_0000;
               if (can_start && f17 > s_up + hz) begin
                  state_d = pump_fan_staging_pkg::ST_START_WAIT;
               end else if (aux_cnt_q != 3'd0 && f17 + hz < l_dn) begin
                  state_d = pump_fan_staging_pkg::ST_STOP_WAIT;
               end
            end
            pump_fan_staging_pkg::ST_START_WAIT: begin
               if (!can_start || !(f17 + hz > s_up)) begin
                  state_d = pump_fan_staging_pkg::ST_IDLE;
               end else if (tick) begin
                  dly_cnt_d = dly_cnt_q + 32'h0000_0001;
                  if (dly_cnt_d >= cfg_q[pump_fan_staging_pkg::IDX_START_DLY]) begin
                     // One motor on, frequency steps down, timer restarts
                     run_d[next_free[2:0]] = 1'b1;
                     aux_cnt_d = aux_cnt_q + 3'd1;
                     step_d.valid = 1'b1;
                     step_d.amount = (s_up > l_up) ? 16'(s_up - l_up) : 16'h0000;
                     state_d = pump_fan_staging_pkg::ST_IDLE;
                  end
               end
            end
            pump_fan_staging_pkg::ST_STOP_WAIT: begin
               if (aux_cnt_q == 3'd0 || !(f17 < l_dn + hz)) begin
                  state_d = pump_fan_staging_pkg::ST_IDLE;
               end else if (tick) begin
                  dly_cnt_d = dly_cnt_q + 32'h0000_0001;
                  if (dly_cnt_d >= cfg_q[pump_fan_staging_pkg::IDX_STOP_DLY]) begin
                     // Latest motor off, frequency steps up, timer restarts
                     if (last_run[3]) begin
                        run_d[last_run[2:0]] = 1'b0;
                     end
                     aux_cnt_d = aux_cnt_q - 3'd1;
                     step_d.valid = 1'b1;
                     step_d.up = 1'b1;
                     step_d.amount = (s_dn > l_dn) ? 16'(s_dn - l_dn) : 16'h0000;
                     state_d = pump_fan_staging_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               state_d = pump_fan_staging_pkg::ST_IDLE;
            end
         endcase
         // Duty rotation: the next enabled relay after the regulated one takes the regulated role, only while no auxiliary runs
         if (rot_en && tick) begin
            rot_cnt_d = rot_cnt_q + 32'h0000_0001;
            if (rot_cnt_d >= cfg_q[pump_fan_staging_pkg::IDX_ROT_INTERVAL]
                && aux_cnt_q == 3'd0 && state_q == pump_fan_staging_pkg::ST_IDLE) begin
               rot_cnt_d = 32'h0000_0000;
               if (next_reg[3]) begin
                  rot_d = next_reg[2:0];
               end
            end
         end
      end
      relay_d = run_d | ((enable && rot_en) ? 6'(1) << rot_d : 6'h00);
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_q <= pump_fan_staging_pkg::ST_IDLE;
         run_q <= 6'h00;
         aux_cnt_q <= 3'd0;
         rot_q <= 3'd0;
         dly_cnt_q <= 32'h0000_0000;
         rot_cnt_q <= 32'h0000_0000;
         tick_cnt_q <= 32'h0000_0000;
         relay_q <= 6'h00;
         step_q <= '{valid: 1'b0, up: 1'b0, amount: 16'h0000};
      end else begin
         state_q <= state_d;
         run_q <= run_d;
         aux_cnt_q <= aux_cnt_d;
         rot_q <= rot_d;
         dly_cnt_q <= dly_cnt_d;
         rot_cnt_q <= rot_cnt_d;
         tick_cnt_q <= tick_cnt_d;
         relay_q <= relay_d;
         step_q <= step_d;
      end
   end

   assign relay_o = relay_q;

   // ---------------------------------------------
   // Regulated motor frequency loop
   // ---------------------------------------------
   freq_loop u_loop (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .enable_i(enable),
      .tick_i(tick),
      .reference_i(cfg_q[pump_fan_staging_pkg::IDX_REFERENCE][15:0]),
      .feedback_i(feedback_i),
      .cfg_i(loop_cfg),
      .step_i(step_q),
      .freq_o(freq)
   );

   assign freq_o = freq;

endmodule

`default_nettype wire

// >>> pump_fan_staging_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------
// Bus and staging checks
// ---------------------------
module pump_fan_staging_assertions #(
   parameter int CTRL_TICK_CYC = 4
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [5:0] relay_o,
   input wire logic [15:0] freq_o
);
   logic [2:0] n_d;
   logic [2:0] n_q;
   logic [15:0] hi_d;
   logic [15:0] hi_q;
   logic [15:0] lo_d;
   logic [15:0] lo_q;
   logic ctl_d;
   logic ctl_q;
   logic rot_vis_q;
   // Runs above start minus 1 Hz and below low plus 1 Hz
   // Regulated relay under rotation is not an auxiliary
   always_comb begin
      ctl_d = ctl_q;
      if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00) begin
         ctl_d = wb_dat_i[0] && wb_dat_i[2];
      end
      n_d = 3'($countones(relay_o)) - {2'b00, rot_vis_q};
      hi_d = (freq_o > 16'h01ea && n_d == n_q) ? hi_q + 16'h0001 : 16'h0000;
      lo_d = (freq_o < 16'h019a && n_d == n_q) ? lo_q + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         n_q <= 3'h0;
         hi_q <= 16'h0000;
         lo_q <= 16'h0000;
         ctl_q <= 1'b0;
         rot_vis_q <= 1'b0;
      end else begin
         ctl_q <= ctl_d;
         rot_vis_q <= ctl_q;
         n_q <= n_d;
         hi_q <= hi_d;
         lo_q <= lo_d;
      end
   end
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence s_aux_up;
      n_d == n_q + 3'h1;
   endsequence
   sequence s_aux_dn;
      n_d + 3'h1 == n_q;
   endsequence
   chk_ack_pulse:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   chk_ack_reply:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   chk_dat_idle:
      assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   chk_one_change:
      assert property (n_d > n_q |-> s_aux_up) else $error("several motors started");
   chk_start_step:
      assert property (s_aux_up |=> freq_o == $past(freq_o) - 16'h0064) else $error("bad start step");
   chk_stop_step:
      assert property (s_aux_dn |=> freq_o == $past(freq_o) + 16'h0064) else $error("bad stop step");
   chk_start_hold:
      assert property (s_aux_up |-> hi_q >= 16'(3 * CTRL_TICK_CYC)) else $error("start too early");
   chk_stop_hold:
      assert property (s_aux_dn |-> lo_q >= 16'(3 * CTRL_TICK_CYC)) else $error("stop too early");
endmodule

bind pump_fan_staging pump_fan_staging_assertions #(.CTRL_TICK_CYC(CTRL_TICK_CYC)) u_chk (
   .sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .relay_o(relay_o),
   .freq_o(freq_o)
);
`default_nettype wire

// >>> process_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------
// Pumps and pressure sensor
// ---------------------------
module process_partner (
   input wire logic clk_i,
   input wire logic [5:0] relay_i,
   input wire logic [15:0] freq_i,
   output logic [15:0] feedback_o
);
   // Half the regulated speed plus a share per line motor
   always @(posedge clk_i) begin
      feedback_o <= (freq_i >> 1) + 16'($countones(relay_i)) * 16'h0040;
   end
endmodule
`default_nettype wire

// >>> pump_fan_staging_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pump_fan_staging_tb_top;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [15:0] feedback_i, freq_o;
   logic [5:0] out_of_service_i = 6'h00, relay_o;
   int err_total = 0, samples_checked = 0;
   always #12.5 sys_clk_i = ~sys_clk_i;
   pump_fan_staging #(.CTRL_TICK_CYC(4)) DUT (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .feedback_i(feedback_i),
      .out_of_service_i(out_of_service_i), .relay_o(relay_o), .freq_o(freq_o));
   process_partner u_proc (.clk_i(sys_clk_i), .relay_i(relay_o), .freq_i(freq_o), .feedback_o(feedback_i));
   // ---------------------------
   // Shared tasks
   // ---------------------------
   task check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge sys_clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 50);
      rd = wb_dat_o;
      check({31'h0, wb_ack_o}, 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   task wait_relay(input logic [5:0] exp);
      logic [5:0] old;
      int i;
      old = relay_o;
      for (i = 0; i < 3000 && relay_o === old; i++) @(posedge sys_clk_i);
      check({26'h0, relay_o}, {26'h0, exp});
   endtask
   task stop_test;
      $display("errors %0d checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ---------------------------
   // Scenarios
   // ---------------------------
   task reg_defaults;
      logic [7:0] a [6] = '{8'h00, 8'h08, 8'h14, 8'h34, 8'h3c, 8'h48};
      logic [31:0] e [6] = '{32'h0, 32'h1f4, 32'h190, 32'h1008, 32'h1f4, 32'h0};
      for (int k = 0; k < 6; k++) begin
         wb(1'b0, a[k], 32'h0);
         check(rd, e[k]);
      end
      wb(1'b1, 8'h40, 32'hffffffff);
      wb(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0010_0000);
   endtask
   task stage_up;
      wb(1'b1, 8'h20, 32'h4);
      wb(1'b1, 8'h24, 32'h4);
      wb(1'b1, 8'h3c, 32'h3e8);
      wb(1'b1, 8'h34, 32'h4000);
      wb(1'b1, 8'h04, 32'h190);
      wb(1'b1, 8'h00, 32'h1);
      wait_relay(6'h01);
      wait_relay(6'h03);
      wait_relay(6'h07);
      repeat (400) @(posedge sys_clk_i);
      check({31'h0, feedback_i > 16'h0188 && feedback_i < 16'h0198}, 32'h1);
      wb(1'b0, 8'h40, 32'h0);
      check({29'h0, rd[18:16]}, 32'h3);
   endtask
   task stage_down;
      wb(1'b1, 8'h04, 32'h40);
      wait_relay(6'h03);
      wait_relay(6'h01);
      wait_relay(6'h00);
   endtask
   task interlock_skip;
      out_of_service_i <= 6'h02;
      wb(1'b1, 8'h04, 32'h190);
      wb(1'b1, 8'h00, 32'h3);
      wait_relay(6'h01);
      wait_relay(6'h05);
      wait_relay(6'h0d);
   endtask
   task disable_drop;
      int i;
      wb(1'b1, 8'h00, 32'h0);
      wait_relay(6'h00);
      for (i = 0; i < 8 && freq_o !== 16'h0000; i++) @(posedge sys_clk_i);
      check({16'h0, freq_o}, 32'h0);
   endtask
   task rotate_duty;
      wb(1'b1, 8'h30, 32'h2);
      wb(1'b1, 8'h04, 32'h40);
      wb(1'b1, 8'h00, 32'h5);
      wait_relay(6'h01);
      wait_relay(6'h02);
      wait_relay(6'h04);
      wb(1'b0, 8'h44, 32'h0);
      check(rd, 32'h0002_0204);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      reg_defaults;
      stage_up;
      stage_down;
      interlock_skip;
      disable_drop;
      rotate_duty;
      stop_test;
   end
   initial begin
      repeat (80000) @(posedge sys_clk_i);
      err_total++;
      stop_test;
   end
endmodule
`default_nettype wire
